/* File: crcu_map.svh */
`ifndef CRCU_MAP_SVH
`define CRCU_MAP_SVH

// Register addresses on the special-function bus
`define CRCU_ADDR_CTRL 8'h84
`define CRCU_ADDR_IN 8'h85
`define CRCU_ADDR_WIN 8'h86
`define CRCU_ADDR_FLIP 8'hDF

// Control register field positions
`define CRCU_BIT_SEL 4
`define CRCU_BIT_INIT 3
`define CRCU_BIT_VAL 2
`define CRCU_PTR_HI 1
`define CRCU_PTR_LO 0

// Reset values and steps
`define CRCU_RST_BYTE 8'h00
`define CRCU_RST_PTR 2'h0
`define CRCU_PTR_STEP 2'h1
`define CRCU_RST_RESULT 32'h0000_0000

// Generators and load values
`define CRCU_POLY32 32'h04C1_1DB7
`define CRCU_POLY16 16'h1021
`define CRCU_INIT_ZERO 32'h0000_0000
`define CRCU_INIT_ONES 32'hFFFF_FFFF

// Byte geometry and input queue
`define CRCU_BITS_PER_BYTE 8
`define CRCU_FIFO_WIDTH 8
`define CRCU_FIFO_DEPTH 8

`endif

/* File: crcu_pkg.sv */
package crcu_pkg;

  // Polynomial select; order matches the control bit encoding
  typedef enum logic {
    crcu_poly32,
    crcu_poly16
  } crcu_poly_e;

  // Whole state of the checksum engine
  typedef struct packed {
    crcu_poly_e poly_sel;   // Current generator
    logic init_val;         // Load value select
    logic [1:0] ptr;        // Result byte pointer
    logic [31:0] result;    // Internal result register
    logic [7:0] in_byte;    // Last accepted input byte
    logic [7:0] flip_byte;  // Last byte written to flip register
    logic [7:0] rdata;      // Registered read data
  } crcu_state_s;

endpackage

/* File: crcu_fifo.sv */
`timescale 1ns/1ns
module crcu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // Depth must be a power of two so pointers wrap naturally
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // All queue state in one word
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage
    logic [AW-1:0] wptr;               // Next slot to fill
    logic [AW-1:0] rptr;               // Oldest slot
    logic [CW-1:0] count;              // Words held
  } crcu_fifo_s;

  crcu_fifo_s q_ff;
  crcu_fifo_s nxt_q;
  logic push;
  logic pop;

  // Honest flags from the occupancy count
  assign in_ready_o = (q_ff.count != CW'(DEPTH));
  assign out_valid_o = (q_ff.count != '0);
  assign out_data_o = q_ff.mem[q_ff.rptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next state: push and pop may happen together
  always_comb begin
    nxt_q = q_ff;
    if (push) begin
      nxt_q.mem[q_ff.wptr] = in_data_i;
      nxt_q.wptr = AW'(q_ff.wptr + 1'b1);
    end
    if (pop) begin
      nxt_q.rptr = AW'(q_ff.rptr + 1'b1);
    end
    if (push && !pop) begin
      nxt_q.count = CW'(q_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_q.count = CW'(q_ff.count - 1'b1);
    end
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

/* File: crcu_top.sv */
`timescale 1ns/1ns
`include "crcu_map.svh"
module crcu_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic byte_in_ready_o,
  output logic fold_busy_o
);
  import crcu_pkg::*;

  // Registered engine state and its next value
  crcu_state_s st_ff;
  crcu_state_s nxt_st;

  // Address decode strobes
  logic wr_ctrl;
  logic wr_in;
  logic wr_win;
  logic wr_flip;
  logic rd_win;
  logic init_req;

  // Input queue handshake
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fold_stall;
  logic fold_pop;

  // Window byte index and control readback
  logic [1:0] win_idx;
  logic [7:0] ctrl_rd;
  crcu_poly_e wr_poly;

  // Reflected form of the 32-bit generator, used by the right-shift engine
  localparam logic [31:0] POLY32_REFL = {<<{`CRCU_POLY32}};

  // Full byte fold in one cycle, so no multi-cycle busy window exists
  function automatic logic [31:0] fold_byte(
    input crcu_poly_e mode,
    input logic [31:0] acc,
    input logic [7:0] din
  );
    logic [31:0] r;
    logic [15:0] s;
    logic out_bit;
    r = acc;
    s = acc[15:0];
    out_bit = 1'b0;
    if (mode == crcu_poly32) begin
      // Reflected engine: byte enters the low end
      r[7:0] = r[7:0] ^ din;
      for (int i = 0; i < `CRCU_BITS_PER_BYTE; i++) begin
        out_bit = r[0];
        r = r >> 1;
        if (out_bit) begin
          r = r ^ POLY32_REFL;
        end
      end
    end else begin
      // Forward engine: byte enters the high end of the 16-bit result
      s[15:8] = s[15:8] ^ din;
      for (int i = 0; i < `CRCU_BITS_PER_BYTE; i++) begin
        out_bit = s[15];
        s = s << 1;
        if (out_bit) begin
          s = s ^ `CRCU_POLY16;
        end
      end
      // Upper half is not part of the 16-bit result and is left alone
      r = {acc[31:16], s};
    end
    return r;
  endfunction

  // Bus strobes, one write strobe per register plus the window read strobe
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `CRCU_ADDR_CTRL);
  assign wr_in = sfr_wr_i && (sfr_addr_i == `CRCU_ADDR_IN);
  assign wr_win = sfr_wr_i && (sfr_addr_i == `CRCU_ADDR_WIN);
  assign wr_flip = sfr_wr_i && (sfr_addr_i == `CRCU_ADDR_FLIP);
  assign rd_win = sfr_rd_i && (sfr_addr_i == `CRCU_ADDR_WIN);

  // Init trigger is a write-only bit, never stored
  assign init_req = wr_ctrl && sfr_wdata_i[`CRCU_BIT_INIT];
  assign wr_poly = crcu_poly_e'(sfr_wdata_i[`CRCU_BIT_SEL]);

  // Software writes to the result outrank folding; the queue holds the byte
  assign fold_stall = init_req || wr_win;
  assign fold_pop = fifo_out_valid && !fold_stall;

  // Pointer to byte index; 16-bit mode aliases the upper two codes
  always_comb begin
    if (st_ff.poly_sel == crcu_poly16) begin
      win_idx = {1'b0, st_ff.ptr[0]};
    end else begin
      win_idx = st_ff.ptr;
    end
  end

  // Control readback; unused and write-only bits read zero
  always_comb begin
    ctrl_rd = `CRCU_RST_BYTE;
    ctrl_rd[`CRCU_BIT_SEL] = st_ff.poly_sel;
    ctrl_rd[`CRCU_BIT_VAL] = st_ff.init_val;
    ctrl_rd[`CRCU_PTR_HI:`CRCU_PTR_LO] = st_ff.ptr;
  end

  // Input byte queue between the bus and the fold engine
  crcu_fifo #(
    .WIDTH(`CRCU_FIFO_WIDTH),
    .DEPTH(`CRCU_FIFO_DEPTH)
  ) u_in_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_in),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sfr_wdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!fold_stall),
    .out_data_o(fifo_out_data)
  );

  // Next-state logic for the whole engine
  always_comb begin
    nxt_st = st_ff;
    // Control write: mode, load value and pointer
    if (wr_ctrl) begin
      nxt_st.poly_sel = wr_poly;
      nxt_st.init_val = sfr_wdata_i[`CRCU_BIT_VAL];
      nxt_st.ptr = sfr_wdata_i[`CRCU_PTR_HI:`CRCU_PTR_LO];
    end
    // Input write: accepted only while the queue has room
    if (wr_in && fifo_in_ready) begin
      nxt_st.in_byte = sfr_wdata_i;
    end
    // Flip register keeps the raw byte; reversal happens on read
    if (wr_flip) begin
      nxt_st.flip_byte = sfr_wdata_i;
    end
    // Result update, highest priority first
    if (init_req) begin
      // Whole 32 bits load, whatever the mode
      nxt_st.result = sfr_wdata_i[`CRCU_BIT_VAL] ? `CRCU_INIT_ONES : `CRCU_INIT_ZERO;
    end else if (wr_win) begin
      nxt_st.result[win_idx*`CRCU_BITS_PER_BYTE +: `CRCU_BITS_PER_BYTE] = sfr_wdata_i;
    end else if (fold_pop) begin
      nxt_st.result = fold_byte(st_ff.poly_sel, st_ff.result, fifo_out_data);
    end
    // Otherwise the result simply holds
    // Window access moves the pointer on
    if (wr_win || rd_win) begin
      nxt_st.ptr = st_ff.ptr + `CRCU_PTR_STEP;
    end
    // Read data is captured on the read strobe
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `CRCU_ADDR_CTRL: begin
          nxt_st.rdata = ctrl_rd;
        end
        `CRCU_ADDR_IN: begin
          nxt_st.rdata = st_ff.in_byte;
        end
        `CRCU_ADDR_WIN: begin
          nxt_st.rdata = st_ff.result[win_idx*`CRCU_BITS_PER_BYTE +: `CRCU_BITS_PER_BYTE];
        end
        `CRCU_ADDR_FLIP: begin
          nxt_st.rdata = {<<{st_ff.flip_byte}};
        end
        default: begin
          // Unmapped address answers zero
          nxt_st.rdata = `CRCU_RST_BYTE;
        end
      endcase
    end
  end

  // Single state register; reset loads constants only, field by field
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      // 32-bit mode, zero load value, pointer on the low byte
      st_ff.poly_sel <= crcu_poly32;
      st_ff.init_val <= 1'b0;
      st_ff.ptr <= `CRCU_RST_PTR;
      st_ff.result <= `CRCU_RST_RESULT;
      st_ff.in_byte <= `CRCU_RST_BYTE;
      st_ff.flip_byte <= `CRCU_RST_BYTE;
      st_ff.rdata <= `CRCU_RST_BYTE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; the queue drains in one cycle, so two-cycle access spacing is enough
  assign sfr_rdata_o = st_ff.rdata;
  assign byte_in_ready_o = fifo_in_ready;
  assign fold_busy_o = fifo_out_valid;

  // Software ordering and byte-wise feeding are the caller's duty

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Init with zero value clears the whole result
  a_init_zero_load:
    assert property (init_req && !sfr_wdata_i[`CRCU_BIT_VAL] |=> st_ff.result == `CRCU_INIT_ZERO)
    else $error("init with zero select did not clear result");

  // Init with ones value sets the whole result
  a_init_ones_load:
    assert property (init_req && sfr_wdata_i[`CRCU_BIT_VAL] |=> st_ff.result == `CRCU_INIT_ONES)
    else $error("init with ones select did not set result");

  // A popped byte is folded with the mode in force
  a_fold_applied:
    assert property (fold_pop |=> st_ff.result ==
      fold_byte($past(st_ff.poly_sel), $past(st_ff.result), $past(fifo_out_data)))
    else $error("input byte not folded into result");

  // Result holds with no cause to change
  a_result_holds:
    assert property (!init_req && !wr_win && !fold_pop |=> $stable(st_ff.result))
    else $error("result changed without cause");

  // Window read advances the pointer by one
  a_ptr_advance:
    assert property (rd_win && !wr_ctrl |=> st_ff.ptr == $past(st_ff.ptr) + `CRCU_PTR_STEP)
    else $error("pointer did not advance after window read");

  // 16-bit mode: pointer code two reads the low byte
  a_win_alias16:
    assert property (rd_win && st_ff.poly_sel == crcu_poly16 && st_ff.ptr == 2'h2
      |=> sfr_rdata_o == $past(st_ff.result[7:0]))
    else $error("16-bit window alias wrong");

  // 32-bit mode: pointer code three reads the top byte
  a_win_top32:
    assert property (rd_win && st_ff.poly_sel == crcu_poly32 && st_ff.ptr == 2'h3
      |=> sfr_rdata_o == $past(st_ff.result[31:24]))
    else $error("32-bit window top byte wrong");

  // Flip register returns the reversed byte
  a_flip_reverse:
    assert property (wr_flip ##1 (sfr_rd_i && sfr_addr_i == `CRCU_ADDR_FLIP && !wr_flip)
      |=> sfr_rdata_o == {<<{$past(sfr_wdata_i, 2)}})
    else $error("flip readback not reversed");

  // Upper control bits and init bit always read zero
  a_ctrl_unused:
    assert property (sfr_rd_i && sfr_addr_i == `CRCU_ADDR_CTRL
      |=> sfr_rdata_o[7:5] == 3'h0 && sfr_rdata_o[`CRCU_BIT_INIT] == 1'b0)
    else $error("unused control bits not zero");

  // Accepted byte into an idle queue is popped for folding in the next cycle unless stalled
  a_fold_prompt:
    assert property (wr_in && fifo_in_ready && !fifo_out_valid ##1 !fold_stall |-> fold_pop)
    else $error("byte not folded promptly");

  // Main scenarios
  c_init_load: cover property (init_req ##1 wr_in ##2 rd_win);
  c_fold_16: cover property (fold_pop && st_ff.poly_sel == crcu_poly16);
  c_fifo_full: cover property (wr_in && !fifo_in_ready);
  c_win_write: cover property (wr_win ##1 wr_win);
endmodule

/* File: crcu_top_tb.sv */
`timescale 1ns/1ns
`include "crcu_map.svh"
module crcu_top_tb;
  // Bench-driven register bus
  logic mclk_i;
  logic rst_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic byte_in_ready_o;
  logic fold_busy_o;
  // Verdict counters
  int error_cnt = 0;
  int n_tests = 0;
  // Reference copy of the result and mode
  logic [31:0] m_res;
  logic m16;
  logic [7:0] v;
  logic [7:0] msg [4] = '{8'hAA, 8'hBB, 8'hCC, 8'h63};
  logic [7:0] flips [4] = '{8'hC0, 8'h05, 8'h01, 8'h3C};
  // Reversed forms worked out by hand
  logic [7:0] flips_rev [4] = '{8'h03, 8'hA0, 8'h80, 8'h3C};

  crcu_top dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .byte_in_ready_o(byte_in_ready_o),
    .fold_busy_o(fold_busy_o)
  );

  // 25 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Reference fold, written from the algorithm, not from the design
  function automatic logic [31:0] fold(input logic [31:0] res, input logic w16, input logic [7:0] b);
    logic [15:0] s;
    logic [31:0] l;
    s = res[15:0] ^ {b, 8'h00};
    l = res ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      s = s[15] ? ((s << 1) ^ 16'h1021) : (s << 1);
      l = l[0] ? ((l >> 1) ^ 32'hEDB88320) : (l >> 1);
    end
    // Upper half stays put in 16-bit mode
    return w16 ? {res[31:16], s} : l;
  endfunction

  // Window byte that a pointer value should show
  function automatic logic [7:0] exp_byte(input logic [1:0] p);
    return m16 ? m_res[{p[0], 3'b000} +: 8] : m_res[{p, 3'b000} +: 8];
  endfunction

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One write strobe; next access lands two cycles later, after the fold
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
  endtask

  // One read strobe; data is registered, so look just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask

  // Control write, keeping the reference in step
  task automatic ctl(input logic sel, input logic val, input logic ini, input logic [1:0] p);
    wr(`CRCU_ADDR_CTRL, {3'b000, sel, ini, val, p});
    m16 = sel;
    if (ini)
      m_res = val ? 32'hFFFFFFFF : 32'h00000000;
  endtask

  // Feed one message byte; queue must show it pending for a cycle
  task automatic feed(input logic [7:0] b);
    wr(`CRCU_ADDR_IN, b);
    #1 chk({7'h00, fold_busy_o}, 8'h01);
    m_res = fold(m_res, m16, b);
  endtask

  // Four window reads from pointer zero; pointer wraps back to zero
  task automatic win4();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(`CRCU_ADDR_WIN, d);
      chk(d, exp_byte(2'(i)));
    end
  endtask

  // Closing point for both the main sequence and the watchdog
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_wdata_i = 8'h00;
    m_res = 32'h00000000;
    m16 = 1'b0;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset values, plus an unmapped place
    chk({7'h00, byte_in_ready_o}, 8'h01);
    chk({7'h00, fold_busy_o}, 8'h00);
    foreach (flips[i]) begin
      rd(i == 0 ? `CRCU_ADDR_CTRL : i == 1 ? `CRCU_ADDR_IN : i == 2 ? `CRCU_ADDR_FLIP : 8'h87, v);
      chk(v, 8'h00);
    end
    win4();
    // Bit reversal of several patterns
    foreach (flips[i]) begin
      wr(`CRCU_ADDR_FLIP, flips[i]);
      rd(`CRCU_ADDR_FLIP, v);
      chk(v, flips_rev[i]);
    end
    // Unused bits and the trigger bit read zero
    wr(`CRCU_ADDR_CTRL, 8'hFF);
    rd(`CRCU_ADDR_CTRL, v);
    chk(v, 8'h17);
    // Every mode and every load value
    for (int s = 0; s < 2; s++) begin
      for (int l = 0; l < 2; l++) begin
        ctl(s[0], l[0], 1'b1, 2'h0);
        win4();
        for (int k = 0; k < 3; k++)
          feed(msg[k]);
        win4();
        // Idle time must not disturb the result
        repeat (10) @(posedge mclk_i);
        win4();
      end
    end
    rd(`CRCU_ADDR_IN, v);
    chk(v, 8'hCC);
    // Window writes replace bytes and step the pointer
    ctl(1'b0, 1'b1, 1'b1, 2'h1);
    wr(`CRCU_ADDR_WIN, 8'h11);
    wr(`CRCU_ADDR_WIN, 8'h22);
    m_res[23:8] = 16'h2211;
    ctl(1'b0, 1'b1, 1'b0, 2'h0);
    win4();
    feed(8'h63);
    win4();
    // Pointer two in 16-bit mode aliases the low byte
    ctl(1'b1, 1'b0, 1'b1, 2'h2);
    wr(`CRCU_ADDR_WIN, 8'h5A);
    m_res[7:0] = 8'h5A;
    ctl(1'b1, 1'b0, 1'b0, 2'h0);
    win4();
    // Back-to-back input bytes, one per cycle, through the queue
    @(posedge mclk_i);
    sfr_addr_i <= `CRCU_ADDR_IN;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= msg[0];
    for (int k = 1; k < 4; k++) begin
      @(posedge mclk_i);
      sfr_wdata_i <= msg[k];
    end
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
    #1 chk({7'h00, fold_busy_o}, 8'h01);
    for (int k = 0; k < 4; k++)
      m_res = fold(m_res, m16, msg[k]);
    repeat (4) @(posedge mclk_i);
    win4();
    // Unmapped write leaves everything alone
    wr(8'h87, 8'hFF);
    rd(8'h87, v);
    chk(v, 8'h00);
    win4();
    give_verdict();
  end
endmodule
